// ---- design/pfpm_pkg.sv ----
package pfpm_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int DET_US = 6;
  localparam int DET_CYC = (DET_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int OT_MS = 2;
  localparam int OT_CYC = (CLK_HZ / 1000) * OT_MS;
  localparam int RETRY_MS = 130;
  localparam int RETRY_CYC = (CLK_HZ / 1000) * RETRY_MS;
  localparam int CNTW = 24;
  localparam int NCH = 6;
  localparam int CH_UV = 0;
  localparam int CH_OV = 1;
  localparam int CH_TRK = 2;
  localparam int CH_OT = 3;
  localparam int CH_OTW = 4;
  localparam int CH_PG = 5;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SETPT = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;

  localparam logic [7:0] UV_BASE = 8'd75;
  localparam logic [7:0] UV_STEP = 8'd5;
  localparam logic [7:0] OV_BASE = 8'd110;
  localparam logic [7:0] OV_STEP = 8'd10;
  localparam logic [7:0] PG_BASE = 8'd90;
  localparam logic [7:0] PG_STEP = 8'd5;
  localparam logic [7:0] PG_HI = 8'd110;
  localparam logic [23:0] PCT_SCALE = 24'd100;
  localparam int OV_FLOOR_MV = 1000;
  localparam logic [23:0] OV_FLOOR_LIM = 24'(OV_FLOOR_MV * 100);
  localparam logic signed [12:0] TRK_MV = 13'sd250;
  localparam logic signed [8:0] OT_OFF_C = 9'sd120;
  localparam logic signed [8:0] OT_ON_C = 9'sd110;
  localparam logic signed [8:0] OTW_C = 9'sd120;
  localparam logic signed [8:0] OTW_HYST = 9'sd3;

  typedef enum logic [1:0] {FSM_OFF, FSM_ON, FSM_RETRY, FSM_LATCH} pfpm_fsm_t;

  typedef struct packed {
    logic pg_sel;
    logic [1:0] ov_sel;
    logic [1:0] uv_sel;
    logic trk_lat;
    logic trk_en;
    logic ot_lat;
    logic ov_lat;
    logic uv_lat;
    logic en;
  } pfpm_ctrl_t;

  localparam pfpm_ctrl_t CTRL_RST = 11'h201;
  localparam logic [12:0] SETPT_RST = 13'h01f4;

  typedef struct packed {
    logic [3:0] cause;
    logic otw;
    logic pg;
    logic on;
  } pfpm_stat_t;
endpackage

// ---- design/pfpm_top.sv ----
// How it works
// - undervoltage level 75 percent default, 5 percent steps, at most 90 percent
// - undervoltage and tracking faults turn off 6 us after threshold crossing
// - overtemperature retries every 130 ms by default, latching selectable
// - shutdown at 120 C, restart allowed only at or below 110 C
// - overtemperature turn-off comes 2 ms after reaching 120 C
// - tracking off by default; when on, latching or 130 ms retry
// - tracking armed only during ramp up, trips beyond 250 mV either way
// - warning always on, status bit set at 120 C, clears 3 C lower
// - warning indication asserts 6 us after exceeding threshold
// - window pin high inside good window, low outside it
// - window low bound 90 percent default, 95 percent option, high bound 110
// - window pin changes 6 us after crossing either bound
// - overvoltage level never below 1.0 V
// - overvoltage level 130 percent default, 10 percent steps from 110
`timescale 1ns/1ps
`default_nettype none
module pfpm_top
  import pfpm_pkg::*;
#(
  parameter logic [CNTW-1:0] OT_DLY_CYC = CNTW'(OT_CYC),
  parameter logic [CNTW-1:0] RETRY_DLY_CYC = CNTW'(RETRY_CYC)
) (
  input wire logic CLK, // system clock
  input wire logic SYS_RST, // sync reset
  input wire logic HSEL, // slave select
  input wire logic [31:0] HADDR, // byte address
  input wire logic [1:0] HTRANS, // transfer type
  input wire logic HWRITE, // write strobe
  input wire logic [2:0] HSIZE, // word only
  input wire logic [31:0] HWDATA, // write data
  input wire logic HREADY, // bus ready
  output logic HREADYOUT, // slave ready
  output logic HRESP, // always okay
  output logic [31:0] HRDATA, // read data
  input wire logic [12:0] VOUT_MV, // output voltage sample
  input wire logic signed [12:0] TRK_ERR_MV, // tracking error sample
  input wire logic signed [8:0] TEMP_C, // controller temperature
  input wire logic RAMP_UP, // output ramping up
  output logic OUT_ON, // turn-on command
  output logic OUTPUT_WINDOW_OK_PIN, // power good pin
  output logic OT_WARN // overtemperature warning
);

  typedef struct packed {
    pfpm_fsm_t st;
    logic out_on;
    logic [NCH-1:0] flt;
    logic [NCH-1:0][CNTW-1:0] cnt;
    logic [CNTW-1:0] rcnt;
    logic [3:0] cause;
    logic ot_off;
    pfpm_ctrl_t ctrl;
    logic [12:0] setpt;
    logic [31:0] rdata;
    logic [7:0] aaddr;
    logic awr;
    logic asel;
  } pfpm_state_t;

  pfpm_state_t s_reg;
  pfpm_state_t s_next;
  logic [NCH-1:0] raw;
  logic [CNTW-1:0] lim [NCH];
  logic [7:0] uv_pct;
  logic [7:0] ov_pct;
  logic [7:0] pg_pct;
  logic [23:0] v100;
  logic [23:0] uv_lim;
  logic [23:0] ov_lim;
  logic [23:0] pg_lo;
  logic [23:0] pg_hi;
  logic cool;
  logic trk_big;
  logic wr_ctrl;
  logic [3:0] lat_sel;
  logic lat_hit;
  pfpm_stat_t stat;

  always_comb begin
    uv_pct = UV_BASE + UV_STEP * {6'h0, s_reg.ctrl.uv_sel};
    ov_pct = OV_BASE + OV_STEP * {6'h0, s_reg.ctrl.ov_sel};
    pg_pct = PG_BASE + PG_STEP * {7'h0, s_reg.ctrl.pg_sel};
    // compare in percent-scaled millivolts so no divider is needed
    v100 = 24'(VOUT_MV) * PCT_SCALE;
    uv_lim = 24'(s_reg.setpt) * {16'h0, uv_pct};
    ov_lim = 24'(s_reg.setpt) * {16'h0, ov_pct};
    if (ov_lim < OV_FLOOR_LIM) begin
      ov_lim = OV_FLOOR_LIM;
    end
    pg_lo = 24'(s_reg.setpt) * {16'h0, pg_pct};
    pg_hi = 24'(s_reg.setpt) * {16'h0, PG_HI};
    cool = TEMP_C <= OT_ON_C;
    trk_big = (TRK_ERR_MV > TRK_MV) || (TRK_ERR_MV < -TRK_MV);
    // uv is masked while ramping, else every restart would trip it
    raw[CH_UV] = s_reg.out_on && !RAMP_UP && (v100 < uv_lim);
    raw[CH_OV] = s_reg.out_on && (v100 > ov_lim);
    raw[CH_TRK] = s_reg.out_on && s_reg.ctrl.trk_en && RAMP_UP && trk_big;
    raw[CH_OT] = TEMP_C >= OT_OFF_C;
    if (s_reg.flt[CH_OTW]) begin
      raw[CH_OTW] = TEMP_C > (OTW_C - OTW_HYST);
    end else begin
      raw[CH_OTW] = TEMP_C >= OTW_C;
    end
    raw[CH_PG] = (v100 >= pg_lo) && (v100 <= pg_hi);
    for (int i = 0; i < NCH; i++) begin
      lim[i] = (i == CH_OT) ? OT_DLY_CYC : CNTW'(DET_CYC);
    end
  end

  always_comb begin
    s_next = s_reg;
    wr_ctrl = 1'b0;
    lat_sel = {s_reg.ctrl.ot_lat, s_reg.ctrl.trk_lat, s_reg.ctrl.ov_lat, s_reg.ctrl.uv_lat};
    lat_hit = |(s_reg.flt[CH_OT:CH_UV] & lat_sel);
    stat.cause = s_reg.cause;
    stat.otw = s_reg.flt[CH_OTW];
    stat.pg = s_reg.flt[CH_PG];
    stat.on = s_reg.out_on;

    // detection filters; fault channels drop at once when the condition goes
    for (int i = 0; i < NCH; i++) begin
      if (raw[i] == s_reg.flt[i]) begin
        s_next.cnt[i] = '0;
      end else if (i < CH_OTW && !raw[i]) begin
        s_next.flt[i] = 1'b0;
        s_next.cnt[i] = '0;
      end else if (s_reg.cnt[i] == lim[i] - 1'b1) begin
        s_next.flt[i] = raw[i];
        s_next.cnt[i] = '0;
      end else begin
        s_next.cnt[i] = s_reg.cnt[i] + 1'b1;
      end
    end

    // data phase of the previous address phase
    if (s_reg.asel && s_reg.awr) begin
      if (s_reg.aaddr == OFS_CTRL) begin
        s_next.ctrl = HWDATA[10:0];
        wr_ctrl = 1'b1;
      end else if (s_reg.aaddr == OFS_SETPT) begin
        s_next.setpt = HWDATA[12:0];
      end else if (s_reg.aaddr == OFS_STAT) begin
        s_next.cause = s_reg.cause & ~HWDATA[6:3];
      end
    end

    s_next.asel = HSEL && HTRANS[1] && HREADY;
    s_next.awr = HWRITE;
    s_next.aaddr = HADDR[7:0];
    s_next.rdata = '0;
    if (s_next.asel && !HWRITE) begin
      if (HADDR[7:0] == OFS_CTRL) begin
        s_next.rdata = {21'h0, s_reg.ctrl};
      end else if (HADDR[7:0] == OFS_SETPT) begin
        s_next.rdata = {19'h0, s_reg.setpt};
      end else if (HADDR[7:0] == OFS_STAT) begin
        s_next.rdata = {25'h0, stat};
      end
    end

    case (s_reg.st)
      FSM_OFF: begin
        if (s_next.ctrl.en && (!s_reg.ot_off || cool)) begin
          s_next.st = FSM_ON;
          s_next.ot_off = 1'b0;
        end
      end
      FSM_ON: begin
        if (!s_next.ctrl.en) begin
          s_next.st = FSM_OFF;
        end else if (|s_reg.flt[CH_OT:CH_UV]) begin
          s_next.cause = s_next.cause | s_reg.flt[CH_OT:CH_UV];
          s_next.ot_off = s_reg.flt[CH_OT];
          s_next.rcnt = '0;
          if (|(s_reg.flt[CH_OT:CH_UV] & lat_sel)) begin
            s_next.st = FSM_LATCH;
          end else begin
            s_next.st = FSM_RETRY;
          end
        end
      end
      FSM_RETRY: begin
        if (!s_next.ctrl.en) begin
          s_next.st = FSM_OFF;
        end else if (s_reg.rcnt == RETRY_DLY_CYC - 1'b1) begin
          // a hot part keeps waiting, counter parked at the end
          if (!s_reg.ot_off || cool) begin
            s_next.st = FSM_ON;
            s_next.ot_off = 1'b0;
          end
        end else begin
          s_next.rcnt = s_reg.rcnt + 1'b1;
        end
      end
      FSM_LATCH: begin
        if (!s_next.ctrl.en) begin
          s_next.st = FSM_OFF;
        end else if (wr_ctrl && (!s_reg.ot_off || cool)) begin
          s_next.st = FSM_ON;
          s_next.ot_off = 1'b0;
        end
      end
      default: begin
        s_next.st = FSM_OFF;
      end
    endcase
    s_next.out_on = s_next.st == FSM_ON;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s_reg <= '0;
      s_reg.st <= FSM_OFF;
      s_reg.ctrl <= CTRL_RST;
      s_reg.setpt <= SETPT_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      HREADYOUT <= 1'b0;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  assign HRDATA = s_reg.rdata;
  assign OUT_ON = s_reg.out_on;
  assign OUTPUT_WINDOW_OK_PIN = s_reg.flt[CH_PG];
  assign OT_WARN = s_reg.flt[CH_OTW];

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_uv_range: assert property (uv_pct >= UV_BASE && uv_pct <= 8'd90)
    else $error("uv percent out of range");
  a_uv_delay: assert property ($rose(s_reg.flt[CH_UV]) |-> $past(raw[CH_UV], DET_CYC))
    else $error("uv trip without full delay");
  a_trk_delay: assert property ($rose(s_reg.flt[CH_TRK]) |-> $past(s_reg.cnt[CH_TRK]) == 24'(DET_CYC - 1))
    else $error("tracking trip delay wrong");
  a_ot_delay: assert property ($rose(s_reg.flt[CH_OT]) |-> $past(s_reg.cnt[CH_OT]) == OT_DLY_CYC - 1'b1)
    else $error("overtemp trip delay wrong");
  a_fault_mode: assert property (s_reg.st == FSM_ON && s_next.ctrl.en && |s_reg.flt[CH_OT:CH_UV]
    |=> (s_reg.st == FSM_LATCH) == $past(lat_hit))
    else $error("fault mode choice wrong");
  a_ot_restart: assert property ($past(s_reg.ot_off) && $rose(s_reg.out_on) |-> $past(TEMP_C) <= OT_ON_C)
    else $error("restart while hot");
  a_retry_hold: assert property ($rose(s_reg.st == FSM_RETRY) |-> !s_reg.out_on [*8])
    else $error("retry did not hold output off");
  a_latch_hold: assert property (s_reg.st == FSM_LATCH && !wr_ctrl |=> !s_reg.out_on)
    else $error("latched off left without re-enable");
  a_trk_arm: assert property (s_reg.flt[CH_TRK] |-> $past(RAMP_UP) && $past(s_reg.ctrl.trk_en))
    else $error("tracking tripped while not armed");
  a_trk_level: assert property (raw[CH_TRK] |-> TRK_ERR_MV > TRK_MV || TRK_ERR_MV < -TRK_MV)
    else $error("tracking trip below 250 mV");
  a_otw_set: assert property ($rose(OT_WARN) |-> $past(raw[CH_OTW], DET_CYC))
    else $error("warning set early or cold");
  a_pg_delay: assert property ($changed(OUTPUT_WINDOW_OK_PIN)
    |-> $past(raw[CH_PG], DET_CYC) == OUTPUT_WINDOW_OK_PIN)
    else $error("window pin changed without delay");
  a_pg_low: assert property (pg_pct == 8'd90 || pg_pct == 8'd95)
    else $error("window low bound bad");
  a_ov_floor: assert property (ov_lim >= OV_FLOOR_LIM)
    else $error("ov level below floor");
  a_ov_pct: assert property (s_reg.ctrl.ov_sel == 2'd2 |-> ov_pct == 8'd130)
    else $error("ov default percent wrong");
  a_cnt_restart: assert property (!raw[CH_PG] && !s_reg.flt[CH_PG] |=> s_reg.cnt[CH_PG] == '0)
    else $error("window timer not restarted");

  c_uv_trip: cover property (s_reg.st == FSM_ON ##1 s_reg.st == FSM_RETRY);
  c_retry_on: cover property (s_reg.st == FSM_RETRY ##1 s_reg.st == FSM_ON);
  c_latch: cover property (s_reg.st == FSM_LATCH);
  c_pg_rise: cover property ($rose(OUTPUT_WINDOW_OK_PIN));
endmodule
`default_nettype wire

// ---- tb/pfpm_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pfpm_host_model (
  input wire logic clk, // system clock
  input wire logic pin, // power good pin as seen by the host
  output int flips // pin changes seen so far
);
  logic last = 1'b0;
  initial flips = 0;
  // host only listens; it counts every change of level it sees on the pin
  always @(posedge clk) begin
    last <= pin;
    if (pin !== last) flips <= flips + 1;
  end
endmodule
`default_nettype wire

// ---- tb/test_pol_fault_protection_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_pol_fault_protection_monitor;
  import pfpm_pkg::*;
  localparam int RT = 50;
  localparam int OTD = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel, hwrite, hready, hresp, ramp, on, pg, warn;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [12:0] vout;
  logic signed [12:0] trk;
  logic signed [8:0] temp;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  int sp = 500;
  int flips, f0;
  pfpm_ctrl_t c;

  pfpm_top #(.OT_DLY_CYC(CNTW'(OTD)), .RETRY_DLY_CYC(CNTW'(RT))) u_pfpm_top (
    .CLK(clk), .SYS_RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HREADYOUT(hready), .HRESP(hresp), .HRDATA(hrdata), .VOUT_MV(vout),
    .TRK_ERR_MV(trk), .TEMP_C(temp), .RAMP_UP(ramp), .OUT_ON(on),
    .OUTPUT_WINDOW_OK_PIN(pg), .OT_WARN(warn));
  pfpm_host_model u_pfpm_host_model (.clk(clk), .pin(pg), .flips(flips));

  initial forever #12.5 clk = ~clk;

  task tally_and_finish;
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures = failures + 1;
      tally_and_finish();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // master holds each phase until hready is seen high at an edge
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
    check(hresp, 1'b0);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, r);
  endtask

  task relatch;
    c.en = 1'b0;
    wr(OFS_CTRL, 32'(c));
    c.en = 1'b1;
    wr(OFS_CTRL, 32'(c));
    hold(4);
  endtask

  function automatic logic [12:0] ceil_pct(input int s, input int p);
    return 13'((s * p + 99) / 100);
  endfunction

  // the floor keeps a low setpoint from pulling the trip level under 1 V
  function automatic logic [12:0] ov_lim(input int s, input int p);
    return 13'(((s * p > 100000) ? s * p : 100000) / 100);
  endfunction

  task mcase(input logic [12:0] v, input logic signed [12:0] e, input logic rp, input logic tr);
    @(posedge clk);
    vout <= v; trk <= e; ramp <= rp;
    hold(DET_CYC + 6);
    check(on, !tr);
    @(posedge clk);
    vout <= sp[12:0]; trk <= 13'sh000; ramp <= 1'b0;
    hold(RT + 30);
    check(on, 1'b1);
  endtask

  task pgc(input logic [12:0] v, input logic e);
    logic p;
    p = pg;
    @(posedge clk);
    vout <= v;
    hold(DET_CYC - 6);
    check(pg, p);
    hold(12);
    check(pg, e);
  endtask

  task settemp(input logic signed [8:0] t, input int n);
    @(posedge clk);
    temp <= t;
    hold(n);
  endtask

  initial begin
    hsel = 1'b0; htrans = 2'h0; hwrite = 1'b0; haddr = 32'h0; hwdata = 32'h0;
    vout = 13'h1f4; trk = 13'sh000; temp = 9'sh019; ramp = 1'b0;
    void'($urandom(41));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    hold(3);
    ahb(1'b0, OFS_CTRL, 32'h0, r);
    check(r, 32'h201);
    ahb(1'b0, 8'h0c, 32'h0, r);
    check(r, 32'h0);
    @(posedge clk);
    vout <= 13'h176;
    hold(DET_CYC - 20);
    @(posedge clk);
    vout <= 13'h1f4;
    @(posedge clk);
    vout <= 13'h176;
    hold(DET_CYC - 20);
    check(on, 1'b1);
    mcase(13'h1f4, 13'sh000, 1'b0, 1'b0);
    mcase(13'h176, 13'sh000, 1'b0, 1'b1);
    mcase(13'h177, 13'sh000, 1'b0, 1'b0);
    for (int n = 0; n < 4; n++) begin
      sp = 1000 + $urandom % 2001;
      c = CTRL_RST; c.uv_sel = 2'(n); c.ov_sel = 2'(n);
      wr(OFS_CTRL, 32'(c));
      wr(OFS_SETPT, sp);
      mcase(ceil_pct(sp, 75 + 5 * n) - 13'h1, 13'sh000, 1'b0, 1'b1);
      mcase(ceil_pct(sp, 75 + 5 * n), 13'sh000, 1'b0, 1'b0);
      mcase(ov_lim(sp, 110 + 10 * n) + 13'h1, 13'sh000, 1'b0, 1'b1);
      mcase(ov_lim(sp, 110 + 10 * n), 13'sh000, 1'b0, 1'b0);
    end
    sp = 500;
    c = CTRL_RST; c.ov_sel = 2'h0;
    wr(OFS_CTRL, 32'(c));
    wr(OFS_SETPT, sp);
    mcase(13'h3e9, 13'sh000, 1'b0, 1'b1);
    mcase(13'h3e8, 13'sh000, 1'b0, 1'b0);
    sp = 1000 + $urandom % 2001;
    wr(OFS_SETPT, sp);
    mcase(sp[12:0], 13'sh12c, 1'b1, 1'b0);
    hold(300);
    f0 = flips;
    for (int s = 0; s < 2; s++) begin
      c = CTRL_RST; c.pg_sel = s[0];
      wr(OFS_CTRL, 32'(c));
      pgc(ceil_pct(sp, 90 + 5 * s) - 13'h1, 1'b0);
      pgc(ceil_pct(sp, 90 + 5 * s), 1'b1);
      pgc(13'(sp * 110 / 100), 1'b1);
      pgc(13'(sp * 110 / 100 + 1), 1'b0);
      pgc(sp[12:0], 1'b1);
    end
    check(flips - f0, 8);
    c = CTRL_RST; c.trk_en = 1'b1;
    wr(OFS_CTRL, 32'(c));
    mcase(sp[12:0], 13'sh0fb, 1'b1, 1'b1);
    mcase(sp[12:0], -13'sh0fb, 1'b1, 1'b1);
    mcase(sp[12:0], 13'sh0fa, 1'b1, 1'b0);
    mcase(sp[12:0], -13'sh0fa, 1'b1, 1'b0);
    mcase(sp[12:0], 13'sh190, 1'b0, 1'b0);
    c.trk_lat = 1'b1;
    wr(OFS_CTRL, 32'(c));
    @(posedge clk);
    trk <= 13'sh12c; ramp <= 1'b1;
    hold(DET_CYC + RT + 40);
    check(on, 1'b0);
    @(posedge clk);
    trk <= 13'sh000; ramp <= 1'b0;
    relatch();
    check(on, 1'b1);
    c = CTRL_RST;
    wr(OFS_CTRL, 32'(c));
    settemp(9'sh077, DET_CYC + 10);
    check(warn, 1'b0);
    check(on, 1'b1);
    settemp(9'sh078, 10);
    check(on, 1'b1);
    hold(20);
    check(on, 1'b0);
    hold(DET_CYC - 40);
    check(warn, 1'b0);
    hold(16);
    check(warn, 1'b1);
    settemp(9'sh076, 300);
    check(on, 1'b0);
    check(warn, 1'b1);
    ahb(1'b0, OFS_STAT, 32'h0, r);
    check(r[2], 1'b1);
    settemp(9'sh075, DET_CYC + 10);
    check(warn, 1'b0);
    settemp(9'sh06f, 10);
    check(on, 1'b0);
    settemp(9'sh06e, 10);
    check(on, 1'b1);
    c.ot_lat = 1'b1;
    wr(OFS_CTRL, 32'(c));
    settemp(9'sh07d, 40);
    check(on, 1'b0);
    settemp(9'sh064, RT + 40);
    check(on, 1'b0);
    relatch();
    check(on, 1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
